// File: hdl/misc_status_pkg.sv
`default_nettype none
package misc_status_pkg;
  // channel and scratchpad geometry
  localparam int NCH = 8;
  localparam int NSCR = 10;
  localparam logic [3:0] SCR_LAST = 4'h9;
  // scratch slots: oem word, unpaged user word, paged words
  localparam int SCR_OEM = 0;
  localparam int SCR_USER = 1;
  localparam int SCR_PAGED = 2;
  // command codes seen on the command port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
  localparam logic [7:0] CMD_USER_OEM = 8'hB2;
  localparam logic [7:0] CMD_USER_WORD = 8'hB3;
  localparam logic [7:0] CMD_USER_PAGED = 8'hB4;
  localparam logic [7:0] CMD_ECC_INFO = 8'hD0;
  localparam logic [7:0] CMD_DISCHARGE = 8'hD1;
  localparam logic [7:0] CMD_COMMON = 8'hD2;
  localparam logic [7:0] CMD_VOUT_MIN = 8'hD3;
  localparam logic [7:0] CMD_VIN_MIN = 8'hD4;
  // information word layout
  localparam int INFO_ECC_BIT = 5;
  // common status byte layout
  localparam int COM_ALERT = 7;
  localparam int COM_READY = 6;
  localparam int COM_SHCLK = 1;
  localparam int COM_WP = 0;
  localparam logic [3:0] COM_ONES = 4'hF;
  // reset values
  localparam logic [15:0] VOUT_MIN_RST = 16'hFFFF;
  localparam logic [15:0] VIN_MIN_RST = 16'h7BFF;
  localparam logic [15:0] COEFF_RST = 16'h8000;
  // adc source code for the input voltage
  localparam logic [3:0] ADC_VIN = 4'h8;
  // l11 exponent bias so shifts stay non-negative
  localparam logic [5:0] L11_BIAS = 6'h10;
endpackage
`default_nettype wire

// File: hdl/misc_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - refresh info word after por, restore, bulk read
// - info bit 5 low when ecc corrected data
// - early turn-on sets discharge flag, alert low
// - hold channel off until output decays
// - coefficient above one skips discharge check
// - 16-bit coefficient times commanded voltage
// - common byte stays readable while busy
// - busy nacks command, sets busy bits
// - common bit 7 mirrors alert output level
// - common bit 6 high when commands accepted
// - common bits 5 to 2 read ones
// - common bit 1 high when share clock held
// - common bit 0 shows write-protect pin
// - store and restore all scratch words
// - scratch is two words plus eight paged
// - vout minimum preset on por, clear, turn-on
// - vout minimum holds lowest l16 sample
// - no vout minimum on current-sense channels
// - vout minimum frozen when uv detection off
// - vin minimum preset on por, clear, turn-on
// - vin minimum holds lowest l11 sample
// - vin minimum frozen while input too low
module misc_status_regs #(
  parameter logic [15:0] COEFF_ONE = 16'h4000
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // command port from the bus engine
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] cmd_page,
  input wire logic [15:0] cmd_wdata,
  // answer to the bus engine
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [15:0] rsp_data,
  output logic busy_set,
  // device pins, asynchronous
  input wire logic share_clk_low_pin,
  input wire logic wp_pin,
  // other alert sources and alert output
  input wire logic alert_req,
  output logic alert_n,
  // eeprom engine
  input wire logic eeprom_busy,
  input wire logic ecc_update,
  input wire logic ecc_corrected,
  input wire logic ee_load_valid,
  input wire logic [3:0] ee_load_idx,
  input wire logic [15:0] ee_load_data,
  output logic ee_wr_valid,
  output logic [3:0] ee_wr_idx,
  output logic [15:0] ee_wr_data,
  output logic ee_restore_req,
  // sequencer
  input wire logic [misc_status_pkg::NCH-1:0] on_req,
  input wire logic [misc_status_pkg::NCH-1:0] off_req,
  input wire logic [misc_status_pkg::NCH-1:0][15:0] vout_cmd,
  input wire logic [misc_status_pkg::NCH-1:0][15:0] vout_meas,
  output logic [misc_status_pkg::NCH-1:0] chan_on,
  output logic [misc_status_pkg::NCH-1:0] discharge_flag,
  // adc results and tracker controls
  input wire logic adc_valid,
  input wire logic [3:0] adc_chan,
  input wire logic [15:0] adc_data,
  input wire logic [misc_status_pkg::NCH-1:0] uv_enabled,
  input wire logic [misc_status_pkg::NCH-1:0] current_mode,
  input wire logic vin_off
);
  import misc_status_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // all state in one record
  typedef struct packed {
    logic [1:0] sy1; // first sync stage, pins
    logic [1:0] sy2; // second sync stage
    logic ecc_ok; // last ecc update saw no correction
    logic [NCH-1:0][15:0] coeff; // discharge coefficients
    logic [NSCR-1:0][15:0] scr; // scratchpad words
    logic [NCH-1:0][15:0] vmin; // output minimums
    logic [15:0] vinmin; // input minimum
    logic [NCH-1:0] on; // channel in on state
    logic [NCH-1:0] wait_dc; // waiting for decay
    logic [NCH-1:0] dflag; // sticky discharge flag
    logic alert_n; // alert pin level
    logic walk; // store-all in progress
    logic [3:0] widx; // store-all index
    logic ee_wr;
    logic [3:0] ee_idx;
    logic [15:0] ee_dat;
    logic ee_rest;
    logic bset;
    logic rv;
    logic rn;
    logic [15:0] rd;
  } regs_t;

  regs_t q; // current state
  regs_t n; // next state
  logic busy; // refusing commands
  logic [NCH-1:0] dec; // output has decayed

  //////////////////////////////////////////////////////////////////////////
  // l11 to a comparable fixed value
  function automatic logic signed [47:0] l11v(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0] sh;
    m = 48'(signed'(w[10:0]));
    // exponent -16..15 becomes shift 0..31
    sh = 6'({w[15], w[15:11]} + L11_BIAS);
    return m <<< sh;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decay test, one per channel
  // products kept 32 bits wide, no truncation
  for (genvar i = 0; i < NCH; i++) begin : g_dec
    logic [31:0] lim;
    logic [31:0] meas;
    assign lim = 32'(q.coeff[i]) * 32'(vout_cmd[i]);
    assign meas = 32'(vout_meas[i]) * 32'(COEFF_ONE);
    // above one: check skipped
    assign dec[i] = (q.coeff[i] > COEFF_ONE) || (meas < lim);
  end

  // eeprom work or our own store walk
  assign busy = eeprom_busy | q.walk;

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = q;
    // one-cycle pulses default low
    n.ee_wr = 1'b0;
    n.ee_rest = 1'b0;
    n.bset = 1'b0;
    n.rv = 1'b0;
    n.rn = 1'b0;
    // pin synchronisers
    n.sy1 = {share_clk_low_pin, wp_pin};
    n.sy2 = q.sy1;

    // ecc status refresh from eeprom engine
    if (ecc_update) begin
      n.ecc_ok = ~ecc_corrected;
    end

    // scratch reload from eeprom
    if (ee_load_valid && ee_load_idx <= SCR_LAST) begin
      n.scr[ee_load_idx] = ee_load_data;
    end

    // store-all walk, one word per cycle
    if (q.walk) begin
      n.ee_wr = 1'b1;
      n.ee_idx = q.widx;
      n.ee_dat = q.scr[q.widx];
      n.widx = q.widx + 4'h1;
      if (q.widx == SCR_LAST) begin
        n.walk = 1'b0;
      end
    end

    // adc samples into the trackers
    // applied before presets so presets win
    if (adc_valid) begin
      if (adc_chan < ADC_VIN) begin
        // current sense and uv-off block updates
        if (uv_enabled[adc_chan[2:0]] &&
            !(adc_chan[0] && current_mode[adc_chan[2:0]]) &&
            adc_data < q.vmin[adc_chan[2:0]]) begin
          n.vmin[adc_chan[2:0]] = adc_data;
        end
      end else if (adc_chan == ADC_VIN) begin
        // frozen while input is too low
        if (!vin_off &&
            l11v(adc_data) < l11v(q.vinmin)) begin
          n.vinmin = adc_data;
        end
      end
    end

    // command decode
    if (cmd_valid) begin
      n.rv = 1'b1;
      n.rd = 16'h0000;
      if (busy && !(cmd_code == CMD_COMMON && !cmd_write)) begin
        // refuse at once, report busy
        n.rn = 1'b1;
        n.bset = 1'b1;
      end else if (cmd_code == CMD_COMMON) begin
        // readable even while busy
        n.rn = cmd_write;
        n.rd[COM_ALERT] = q.alert_n;
        n.rd[COM_READY] = ~busy;
        n.rd[COM_READY-1:COM_SHCLK+1] = COM_ONES;
        n.rd[COM_SHCLK] = q.sy2[1];
        n.rd[COM_WP] = q.sy2[0];
      end else if (cmd_code == CMD_ECC_INFO) begin
        // read-only, other bits zero
        n.rn = cmd_write;
        n.rd[INFO_ECC_BIT] = q.ecc_ok;
      end else if (cmd_code == CMD_DISCHARGE) begin
        // paged coefficient
        if (cmd_write) begin
          n.coeff[cmd_page] = cmd_wdata;
        end
        n.rd = q.coeff[cmd_page];
      end else if (cmd_code == CMD_USER_OEM) begin
        if (cmd_write) begin
          n.scr[SCR_OEM] = cmd_wdata;
        end
        n.rd = q.scr[SCR_OEM];
      end else if (cmd_code == CMD_USER_WORD) begin
        // unpaged user word
        if (cmd_write) begin
          n.scr[SCR_USER] = cmd_wdata;
        end
        n.rd = q.scr[SCR_USER];
      end else if (cmd_code == CMD_USER_PAGED) begin
        // one word per page
        if (cmd_write) begin
          n.scr[SCR_PAGED + cmd_page] = cmd_wdata;
        end
        n.rd = q.scr[SCR_PAGED + cmd_page];
      end else if (cmd_code == CMD_VOUT_MIN) begin
        // not offered on a current-sense channel
        if (cmd_write || (cmd_page[0] && current_mode[cmd_page])) begin
          n.rn = 1'b1;
        end else begin
          n.rd = q.vmin[cmd_page];
        end
      end else if (cmd_code == CMD_VIN_MIN) begin
        n.rn = cmd_write;
        n.rd = q.vinmin;
      end else if (cmd_code == CMD_STORE_ALL && cmd_write) begin
        // walk starts next cycle, busy meanwhile
        n.walk = 1'b1;
        n.widx = 4'h0;
      end else if (cmd_code == CMD_RESTORE_ALL && cmd_write) begin
        n.ee_rest = 1'b1;
      end else if (cmd_code == CMD_CLEAR_FAULTS && cmd_write) begin
        // page flag and minimums; a new event
        // in this cycle is set again below
        n.dflag[cmd_page] = 1'b0;
        n.vmin[cmd_page] = VOUT_MIN_RST;
        n.vinmin = VIN_MIN_RST;
      end else begin
        // unknown code or wrong direction
        n.rn = 1'b1;
      end
    end

    // channel turn-on with discharge check
    for (int i = 0; i < NCH; i++) begin
      if (off_req[i]) begin
        n.on[i] = 1'b0;
        n.wait_dc[i] = 1'b0;
      end else if (on_req[i] && !q.on[i]) begin
        if (dec[i]) begin
          n.on[i] = 1'b1;
        end else begin
          // still charged: flag and hold off
          n.dflag[i] = 1'b1;
          n.wait_dc[i] = 1'b1;
        end
      end else if (q.wait_dc[i] && dec[i]) begin
        // decayed at last, release
        n.on[i] = 1'b1;
        n.wait_dc[i] = 1'b0;
      end
      // off-to-on edge presets the trackers
      if (n.on[i] && !q.on[i]) begin
        n.vmin[i] = VOUT_MIN_RST;
        n.vinmin = VIN_MIN_RST;
      end
    end

    // alert low on any flag or outside request
    n.alert_n = ~(alert_req | (|q.dflag));

    // synchronous reset overrides everything
    if (srst) begin
      n = '0;
      n.ecc_ok = 1'b1;
      n.alert_n = 1'b1;
      n.coeff = {NCH{COEFF_RST}};
      n.vmin = {NCH{VOUT_MIN_RST}};
      n.vinmin = VIN_MIN_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    q <= n;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign rsp_valid = q.rv;
  assign rsp_nack = q.rn;
  assign rsp_data = q.rd;
  assign busy_set = q.bset;
  assign alert_n = q.alert_n;
  assign ee_wr_valid = q.ee_wr;
  assign ee_wr_idx = q.ee_idx;
  assign ee_wr_data = q.ee_dat;
  assign ee_restore_req = q.ee_rest;
  assign chan_on = q.on;
  assign discharge_flag = q.dflag;

  //////////////////////////////////////////////////////////////////////////
  // checks
  // busy refusal answers nack and busy pulse
  busy_nack_a: assert property (
    @(posedge clk) disable iff (srst)
    cmd_valid && busy && cmd_code != CMD_COMMON
    |=> rsp_valid && rsp_nack && busy_set)
    else $error("busy command not refused");

  // common read always served
  common_busy_a: assert property (
    @(posedge clk) disable iff (srst)
    cmd_valid && !cmd_write && cmd_code == CMD_COMMON
    |=> rsp_valid && !rsp_nack && !busy_set)
    else $error("common read refused");

  // common byte fields
  common_bits_a: assert property (
    @(posedge clk) disable iff (srst)
    cmd_valid && !cmd_write && cmd_code == CMD_COMMON
    |=> rsp_data[5:2] == COM_ONES && rsp_data[15:8] == 8'h00
    && rsp_data[COM_ALERT] == $past(alert_n)
    && rsp_data[COM_READY] == $past(!busy))
    else $error("common byte wrong");

  // flag drives alert one cycle later
  alert_flag_a: assert property (
    @(posedge clk) disable iff (srst)
    |q.dflag |=> !alert_n)
    else $error("alert not asserted");

  // early turn-on flags channel 0
  early_on_a: assert property (
    @(posedge clk) disable iff (srst)
    on_req[0] && !off_req[0] && !q.on[0] && !dec[0]
    |=> discharge_flag[0] && !chan_on[0] ##1 !alert_n)
    else $error("discharge not flagged");

  // turn-on only after decay
  hold_off_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(chan_on[0]) |-> $past(dec[0]))
    else $error("channel on before decay");

  // turn-on presets the minimum
  vmin_preset_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(chan_on[0]) |-> q.vmin[0] == VOUT_MIN_RST
    && q.vinmin == VIN_MIN_RST)
    else $error("minimum not preset");

  // tracker only rises to its preset
  vmin_mono_a: assert property (
    @(posedge clk) disable iff (srst)
    q.vmin[0] > $past(q.vmin[0]) |-> q.vmin[0] == VOUT_MIN_RST)
    else $error("minimum rose");

  // frozen input minimum except presets
  vin_freeze_a: assert property (
    @(posedge clk) disable iff (srst)
    $past(vin_off) && q.vinmin != $past(q.vinmin)
    |-> q.vinmin == VIN_MIN_RST)
    else $error("input minimum moved");
endmodule
`default_nettype wire

// File: dv/ee_model.sv
`timescale 1ns/1ps
`default_nettype none
// eeprom engine stand-in: keeps stored words, replays them on restore
module ee_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // store traffic from the block
  input wire logic ee_wr_valid,
  input wire logic [3:0] ee_wr_idx,
  input wire logic [15:0] ee_wr_data,
  input wire logic ee_restore_req,
  // restore traffic to the block
  output logic eeprom_busy,
  output logic ee_load_valid,
  output logic [3:0] ee_load_idx,
  output logic [15:0] ee_load_data
);
  logic [15:0] mem [16]; // stored words
  logic [3:0] pos; // replay slot, a means idle
  // capture stores, walk all ten slots on restore
  always @(posedge clk) begin
    if (ee_wr_valid)
      mem[ee_wr_idx] <= ee_wr_data;
    if (srst)
      pos <= 4'hA;
    else if (ee_restore_req)
      pos <= 4'h0;
    else if (pos != 4'hA)
      pos <= pos + 4'h1;
  end
  // busy for the whole replay; idle data is scrambled, never stale
  always_comb begin
    eeprom_busy = (pos != 4'hA);
    ee_load_valid = (pos != 4'hA);
    ee_load_idx = pos;
    ee_load_data = ee_load_valid ? mem[pos] : ~mem[pos];
  end
endmodule
`default_nettype wire

// File: dv/misc_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module misc_status_regs_tb;
  import misc_status_pkg::*;
  logic clk, srst, cmd_valid, cmd_write, rsp_valid, rsp_nack, busy_set;
  logic [7:0] cmd_code;
  logic [2:0] cmd_page;
  logic [15:0] cmd_wdata, rsp_data, ee_load_data, ee_wr_data, adc_data;
  logic share_clk_low_pin, wp_pin, alert_req, alert_n, eeprom_busy;
  logic ecc_update, ecc_corrected, ee_load_valid, ee_wr_valid;
  logic ee_restore_req, adc_valid, vin_off;
  logic [3:0] ee_load_idx, ee_wr_idx, adc_chan;
  logic [NCH-1:0] on_req, off_req, chan_on, discharge_flag;
  logic [NCH-1:0] uv_enabled, current_mode;
  logic [NCH-1:0][15:0] vout_cmd, vout_meas;
  int error_cnt, samples_checked, cyc;
  logic [15:0] rd; // last read data
  logic nk, bs; // last nack and busy pulse
  ////////////////////////////////////////
  misc_status_regs dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .rsp_data(rsp_data), .busy_set(busy_set),
    .share_clk_low_pin(share_clk_low_pin), .wp_pin(wp_pin),
    .alert_req(alert_req), .alert_n(alert_n), .eeprom_busy(eeprom_busy),
    .ecc_update(ecc_update), .ecc_corrected(ecc_corrected),
    .ee_load_valid(ee_load_valid), .ee_load_idx(ee_load_idx),
    .ee_load_data(ee_load_data), .ee_wr_valid(ee_wr_valid),
    .ee_wr_idx(ee_wr_idx), .ee_wr_data(ee_wr_data),
    .ee_restore_req(ee_restore_req), .on_req(on_req), .off_req(off_req),
    .vout_cmd(vout_cmd), .vout_meas(vout_meas), .chan_on(chan_on),
    .discharge_flag(discharge_flag), .adc_valid(adc_valid),
    .adc_chan(adc_chan), .adc_data(adc_data), .uv_enabled(uv_enabled),
    .current_mode(current_mode), .vin_off(vin_off));
  ee_model ee (.clk(clk), .srst(srst), .ee_wr_valid(ee_wr_valid),
    .ee_wr_idx(ee_wr_idx), .ee_wr_data(ee_wr_data),
    .ee_restore_req(ee_restore_req), .eeprom_busy(eeprom_busy),
    .ee_load_valid(ee_load_valid), .ee_load_idx(ee_load_idx),
    .ee_load_data(ee_load_data));
  ////////////////////////////////////////
  // one bit widened for the word compare
  function automatic logic [15:0] b(input logic x);
    return {15'h0000, x};
  endfunction
  // expected common byte: alert, ready, share clock, write-protect
  function automatic logic [15:0] com(input logic [3:0] v);
    return {8'h00, v[3:2], 4'hF, v[1:0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one command: strobe a cycle, answer lands one edge later
  task automatic cmd(input logic w, input logic [7:0] c,
                     input logic [2:0] p, input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_page <= p;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    rd = rsp_data;
    nk = rsp_nack;
    bs = busy_set;
    chk("rsp_valid", 16'h0001, b(rsp_valid));
    // end on an edge so the caller's next drive lands on one
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] c,
                      input logic [2:0] p, input logic [15:0] e);
    cmd(1'b0, c, p, 16'h0000);
    chk(nm, e, rd);
  endtask
  task automatic adc(input logic [3:0] ch, input logic [15:0] d);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_chan <= ch;
    adc_data <= d;
    @(posedge clk);
    adc_valid <= 1'b0;
  endtask
  // request turn-on of one channel and let the sequencer settle
  task automatic turn_on(input int ch);
    @(posedge clk);
    on_req[ch] <= 1'b1;
    @(posedge clk);
    on_req[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the sequence length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    {srst, cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
    {alert_req, ecc_update, ecc_corrected, adc_valid, vin_off} = '0;
    {adc_chan, adc_data, on_req, off_req, current_mode} = '0;
    {vout_cmd, vout_meas} = '0;
    srst = 1'b1;
    share_clk_low_pin = 1'b1;
    wp_pin = 1'b0;
    uv_enabled = '1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'h7BFF);
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'hFFFF);
    rchk("info", CMD_ECC_INFO, 3'h0, 16'h0020);
    rchk("common", CMD_COMMON, 3'h0, com(4'b1110));
    share_clk_low_pin <= 1'b0;
    wp_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("common", CMD_COMMON, 3'h0, com(4'b1101));
    ecc_update <= 1'b1;
    ecc_corrected <= 1'b1;
    @(posedge clk);
    ecc_update <= 1'b0;
    rchk("info", CMD_ECC_INFO, 3'h0, 16'h0000);
    cmd(1'b1, CMD_ECC_INFO, 3'h0, 16'hFFFF);
    chk("ro_nack", 16'h0001, b(nk));
    rchk("info", CMD_ECC_INFO, 3'h0, 16'h0000);
    // scratch store, poll while busy, then restore
    cmd(1'b1, CMD_USER_WORD, 3'h0, 16'hBEEF);
    cmd(1'b1, CMD_USER_PAGED, 3'h7, 16'h1234);
    cmd(1'b1, CMD_STORE_ALL, 3'h0, 16'h0000);
    rchk("busy_com", CMD_COMMON, 3'h0, com(4'b1001));
    cmd(1'b0, CMD_ECC_INFO, 3'h0, 16'h0000);
    chk("busy_nack", 16'h0001, b(nk & bs));
    repeat (12) @(posedge clk);
    cmd(1'b1, CMD_USER_WORD, 3'h0, 16'h0000);
    cmd(1'b1, CMD_RESTORE_ALL, 3'h0, 16'h0000);
    repeat (14) @(posedge clk);
    rchk("user", CMD_USER_WORD, 3'h0, 16'hBEEF);
    rchk("paged", CMD_USER_PAGED, 3'h7, 16'h1234);
    // minimum trackers
    adc(4'h0, 16'h1234);
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'h1234);
    adc(4'h0, 16'h2000);
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'h1234);
    uv_enabled[0] <= 1'b0;
    adc(4'h0, 16'h0100);
    uv_enabled[0] <= 1'b1;
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'h1234);
    adc(ADC_VIN, 16'h0A00);
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'h0A00);
    vin_off <= 1'b1;
    adc(ADC_VIN, 16'h0900);
    vin_off <= 1'b0;
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'h0A00);
    // negative exponent: raw code higher, value lower
    adc(ADC_VIN, 16'hFA00);
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'hFA00);
    current_mode[1] <= 1'b1;
    cmd(1'b0, CMD_VOUT_MIN, 3'h1, 16'h0000);
    chk("cur_nack", 16'h0001, b(nk));
    cmd(1'b1, CMD_CLEAR_FAULTS, 3'h0, 16'h0000);
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'hFFFF);
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'h7BFF);
    adc(4'h0, 16'h1234);
    adc(ADC_VIN, 16'h0A00);
    // discharge hold at half of the commanded level
    cmd(1'b1, CMD_DISCHARGE, 3'h0, 16'h2000);
    rchk("coeff", CMD_DISCHARGE, 3'h0, 16'h2000);
    vout_cmd[0] <= 16'd1000;
    vout_meas[0] <= 16'd800;
    turn_on(0);
    chk("held", 16'h0000, b(chan_on[0]));
    chk("dis_flag", 16'h0001, b(discharge_flag[0]));
    chk("alert_n", 16'h0000, b(alert_n));
    rchk("common", CMD_COMMON, 3'h0, com(4'b0101));
    vout_meas[0] <= 16'd100;
    repeat (3) @(posedge clk);
    #1;
    chk("on", 16'h0001, b(chan_on[0]));
    rchk("vout_min", CMD_VOUT_MIN, 3'h0, 16'hFFFF);
    rchk("vin_min", CMD_VIN_MIN, 3'h0, 16'h7BFF);
    vout_cmd[1] <= 16'd1000;
    // far above the coefficient limit: only the skip lets it on
    vout_meas[1] <= 16'h0BB8;
    turn_on(1);
    chk("skip", 16'h0001, b(chan_on[1] & ~discharge_flag[1]));
    test_done();
  end
endmodule
`default_nettype wire
